// File: design/crm_pkg.sv
// Shared constants and helpers of the crate/module command link
package crm_pkg;
  // ==========================================================
  // Word and packet layout
  localparam int WORD_W    = 32;
  localparam int PKT_W     = 25;
  localparam int SLOT_W    = 4;
  localparam int KIND_BIT  = 24;
  localparam int CHAN_HI   = 23;
  localparam int CHAN_LO   = 16;
  localparam int DATA_HI   = 15;
  localparam int ROUTE_HI  = 15;
  localparam int ROUTE_LO  = 8;
  localparam int CODE_HI   = 23;
  localparam int CODE_LO   = 22;
  localparam int ECHO_HI   = 21;
  localparam int ECHO_LO   = 16;
  // ==========================================================
  // Routing byte classes (top two bits)
  localparam logic [1:0] CLS_DATA = 2'h0;
  localparam logic [1:0] CLS_CMD  = 2'h2;
  localparam logic [1:0] CLS_SVC  = 2'h3;
  // ==========================================================
  // Command codes
  localparam logic [1:0] CMD_STOP  = 2'h0;
  localparam logic [1:0] CMD_LOAD  = 2'h1;
  localparam logic [1:0] CMD_RESET = 2'h2;
  localparam logic [1:0] CMD_FIRMWARE_INSTRUCTION_COMMAND = 2'h3;
  // ==========================================================
  // Serial framing
  localparam int FRAME_BITS = 11;
  localparam int PKT_BYTES  = 3;
  localparam int LINE_BITS  = FRAME_BITS * PKT_BYTES;
  localparam int RX_SAMPLES = 10;
  localparam logic [5:0] LINE_BITS_W = 6'h21;
  localparam logic [3:0] RX_LAST     = 4'h9;
  // ==========================================================
  // Reset values and defaults
  localparam int          BIT_DIV_DEF   = 14;
  localparam logic [15:0] MODULE_ID_DEF = 16'h5A3C; // Arbitrary value
  localparam logic        LINE_IDLE     = 1'b1;

  // One 11-bit frame: start, control, data LSB first, stop
  function automatic logic [FRAME_BITS-1:0] frame(input logic ctrl,
                                                  input logic [7:0] d);
    frame = {1'b1, d, ctrl, 1'b0};
  endfunction

  // Host word rebuilt from a module packet and its slot
  function automatic logic [WORD_W-1:0] pack_up(
      input logic [PKT_W-1:0] p, input logic [SLOT_W-1:0] slot);
    pack_up = {p[DATA_HI:0], p[KIND_BIT], 3'h0, slot, p[CHAN_HI:CHAN_LO]};
  endfunction
endpackage

// File: design/crm_buf.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module crm_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  import crm_pkg::*;

  if (DEPTH != 2) begin : g_chk
    $error("crm_buf serves DEPTH of 2 only");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             next_wr_ptr;
  logic             next_rd_ptr;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  // ==========================================================
  // Pointers and flags
  always_comb begin
    push        = in_valid & in_ready;
    pop         = out_valid & out_ready;
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr    <= 1'b0;
      rd_ptr    <= 1'b0;
      count     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_buf_no_overrun: assert property (count == 2'h2 |-> !in_ready)
    else $error("buffer accepts a word while full");
  a_buf_holds_word: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word lost while stalled");
endmodule

// File: design/crm_link.sv
// Crate/module command link: host word packer and module command decoder
`timescale 1ns/1ns
module crm_link #(
  parameter int          BIT_DIV   = crm_pkg::BIT_DIV_DEF,
  parameter logic [15:0] MODULE_ID = crm_pkg::MODULE_ID_DEF
) (
  input  wire logic                        mclk,
  input  wire logic                        reset,
  input  wire logic                        host_valid,
  input  wire logic [crm_pkg::WORD_W-1:0]  host_word,
  output logic                             host_ready,
  output logic                             svc_valid,
  output logic [crm_pkg::WORD_W-1:0]       svc_word,
  output logic                             link_tx,
  output logic [crm_pkg::SLOT_W-1:0]       link_slot,
  input  wire logic                        link_rx,
  input  wire logic                        dsp_based,
  output logic                             mcu_reset,
  output logic                             operating,
  output logic                             load_valid,
  output logic [7:0]                       load_byte,
  input  wire logic [15:0]                 mcu_echo,
  output logic                             fw_valid,
  output logic                             fw_is_cmd,
  output logic [23:0]                      fw_word,
  input  wire logic                        fw_reply_valid,
  input  wire logic [23:0]                 fw_reply,
  output logic                             resp_valid,
  output logic [crm_pkg::PKT_W-1:0]        resp_packet,
  input  wire logic                        resp_ready,
  input  wire logic                        up_valid,
  input  wire logic [crm_pkg::PKT_W-1:0]   up_packet,
  input  wire logic [crm_pkg::SLOT_W-1:0]  up_slot,
  output logic                             host_out_valid,
  output logic [crm_pkg::WORD_W-1:0]       host_out_word
);
  import crm_pkg::*;

  if (BIT_DIV < 4 || BIT_DIV > 255) begin : g_chk
    $error("crm_link BIT_DIV out of range");
  end

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} crm_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BITS = 2'b10} crm_rx_e;
  typedef enum logic [1:0] {DC_IDLE = 2'b01, DC_LOAD = 2'b10} crm_dc_e;

  localparam logic [7:0] DIV_LAST = 8'(BIT_DIV - 1);
  localparam logic [7:0] DIV_MID  = 8'(BIT_DIV / 2);

  // ==========================================================
  // Bit rate divider
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       bit_en;
  logic       smp_en;

  always_comb begin
    next_div_cnt = (div_cnt == DIV_LAST) ? 8'h00 : div_cnt + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_cnt <= 8'h00;
      bit_en  <= 1'b0;
      smp_en  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      bit_en  <= (next_div_cnt == DIV_LAST);
      smp_en  <= (next_div_cnt == DIV_MID);
    end
  end

  // ==========================================================
  // Host word buffer and controller downstream path
  logic                buf_valid;
  logic [WORD_W-1:0]   buf_word;
  logic                buf_ready;

  crm_buf #(.WIDTH(WORD_W), .DEPTH(2)) u_buf (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (host_valid),
    .in_data   (host_word),
    .in_ready  (host_ready),
    .out_valid (buf_valid),
    .out_data  (buf_word),
    .out_ready (buf_ready)
  );

  crm_tx_e             tx_state, next_tx_state;
  logic [LINE_BITS-1:0] tx_sh, next_tx_sh;
  logic [5:0]          tx_left, next_tx_left;
  logic                next_link_tx;
  logic [SLOT_W-1:0]   next_link_slot;
  logic                next_svc_valid;
  logic [WORD_W-1:0]   next_svc_word;
  logic [1:0]          cls;
  logic [PKT_W-1:0]    dn_pkt;

  assign buf_ready = (tx_state == TX_IDLE);

  always_comb begin
    cls    = buf_word[ROUTE_HI -: 2];
    // Kind bit alone crosses; data and channel are reshuffled
    dn_pkt = {buf_word[ROUTE_HI], buf_word[7:0],
              buf_word[WORD_W-1:16]};
    next_tx_state  = tx_state;
    next_tx_sh     = tx_sh;
    next_tx_left   = tx_left;
    next_link_tx   = link_tx;
    next_link_slot = link_slot;
    next_svc_valid = 1'b0;
    next_svc_word  = svc_word;
    case (tx_state)
      TX_IDLE: begin
        if (buf_valid) begin
          if (cls == CLS_SVC) begin
            next_svc_valid = 1'b1;
            next_svc_word  = buf_word;
          end else begin
            next_link_slot = buf_word[ROUTE_LO +: SLOT_W];
            next_tx_sh = {frame(1'b0, dn_pkt[7:0]),
                          frame(1'b0, dn_pkt[15:8]),
                          frame(dn_pkt[KIND_BIT],
                                dn_pkt[CHAN_HI:CHAN_LO])};
            next_tx_left  = LINE_BITS_W;
            next_tx_state = TX_SHIFT;
          end
        end
      end
      TX_SHIFT: begin
        if (bit_en) begin
          next_link_tx = tx_sh[0];
          next_tx_sh   = {1'b1, tx_sh[LINE_BITS-1:1]};
          next_tx_left = tx_left - 6'h01;
          if (tx_left == 6'h01) begin
            next_tx_state = TX_IDLE;
          end
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_state  <= TX_IDLE;
      tx_sh     <= '1;
      tx_left   <= 6'h00;
      link_tx   <= LINE_IDLE;
      link_slot <= '0;
      svc_valid <= 1'b0;
      svc_word  <= '0;
    end else begin
      tx_state  <= next_tx_state;
      tx_sh     <= next_tx_sh;
      tx_left   <= next_tx_left;
      link_tx   <= next_link_tx;
      link_slot <= next_link_slot;
      svc_valid <= next_svc_valid;
      svc_word  <= next_svc_word;
    end
  end

  // ==========================================================
  // Controller upstream path
  always_ff @(posedge mclk) begin
    if (reset) begin
      host_out_valid <= 1'b0;
      host_out_word  <= '0;
    end else begin
      host_out_valid <= up_valid;
      if (up_valid) begin
        host_out_word <= pack_up(up_packet, up_slot);
      end
    end
  end

  // ==========================================================
  // Module serial receiver and packet assembly
  crm_rx_e           rx_state, next_rx_state;
  logic [3:0]        rx_cnt, next_rx_cnt;
  logic [9:0]        rx_sh, next_rx_sh;
  logic [1:0]        byte_idx, next_byte_idx;
  logic              synced, next_synced;
  logic [PKT_W-1:0]  rx_pkt, next_rx_pkt;
  logic              pkt_done, next_pkt_done;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_cnt   = rx_cnt;
    next_rx_sh    = rx_sh;
    next_byte_idx = byte_idx;
    next_synced   = synced;
    next_rx_pkt   = rx_pkt;
    next_pkt_done = 1'b0;
    case (rx_state)
      RX_IDLE: begin
        if (smp_en && !link_rx) begin
          next_rx_state = RX_BITS;
          next_rx_cnt   = 4'h0;
        end
      end
      RX_BITS: begin
        if (smp_en) begin
          next_rx_sh  = {link_rx, rx_sh[9:1]};
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == RX_LAST) begin
            next_rx_state = RX_IDLE;
            if (link_rx && next_rx_sh[0]) begin
              next_synced   = 1'b1;
              next_byte_idx = 2'h1;
              next_rx_pkt   = {1'b1, next_rx_sh[8:1], 16'h0000};
            end else if (link_rx && synced) begin
              if (byte_idx == 2'h0) begin
                next_rx_pkt   = {1'b0, next_rx_sh[8:1], 16'h0000};
                next_byte_idx = 2'h1;
              end else if (byte_idx == 2'h1) begin
                next_rx_pkt[15:8] = next_rx_sh[8:1];
                next_byte_idx     = 2'h2;
              end else begin
                next_rx_pkt[7:0] = next_rx_sh[8:1];
                next_byte_idx    = 2'h0;
                next_pkt_done    = 1'b1;
              end
            end
          end
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 4'h0;
      rx_sh    <= '0;
      byte_idx <= 2'h0;
      synced   <= 1'b0;
      rx_pkt   <= '0;
      pkt_done <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rx_cnt   <= next_rx_cnt;
      rx_sh    <= next_rx_sh;
      byte_idx <= next_byte_idx;
      synced   <= next_synced;
      rx_pkt   <= next_rx_pkt;
      pkt_done <= next_pkt_done;
    end
  end

  // ==========================================================
  // Module command decoder and reply register
  crm_dc_e           dc_state, next_dc_state;
  logic [5:0]        echo_bits, next_echo_bits;
  logic [7:0]        load_lo, next_load_lo;
  logic              next_mcu_reset, next_operating;
  logic              next_load_valid, next_fw_valid, next_fw_is_cmd;
  logic [7:0]        next_load_byte;
  logic [23:0]       next_fw_word;
  logic              next_resp_valid;
  logic [PKT_W-1:0]  next_resp_packet;
  logic [1:0]        code;

  always_comb begin
    code             = rx_pkt[CODE_HI:CODE_LO];
    next_dc_state    = dc_state;
    next_echo_bits   = echo_bits;
    next_load_lo     = load_lo;
    next_mcu_reset   = mcu_reset;
    next_operating   = operating;
    next_load_valid  = 1'b0;
    next_load_byte   = load_byte;
    next_fw_valid    = 1'b0;
    next_fw_is_cmd   = fw_is_cmd;
    next_fw_word     = fw_word;
    next_resp_valid  = resp_valid && !resp_ready;
    next_resp_packet = resp_packet;
    if (operating && fw_reply_valid && !next_resp_valid) begin
      next_resp_valid  = 1'b1;
      next_resp_packet = {1'b1, fw_reply};
    end
    case (dc_state)
      DC_IDLE: begin
        if (pkt_done && rx_pkt[KIND_BIT]) begin
          case (code)
            CMD_STOP: begin
              next_mcu_reset  = 1'b0;
              next_operating  = 1'b0;
              next_resp_valid = 1'b0;
            end
            CMD_RESET: begin
              next_mcu_reset   = 1'b1;
              next_resp_valid  = 1'b1;
              next_resp_packet = {1'b1, CMD_RESET,
                                  rx_pkt[ECHO_HI:ECHO_LO],
                                  MODULE_ID};
            end
            CMD_LOAD: begin
              next_load_valid = 1'b1;
              next_load_byte  = rx_pkt[15:8];
              next_load_lo    = rx_pkt[7:0];
              next_echo_bits  = rx_pkt[ECHO_HI:ECHO_LO];
              next_dc_state   = DC_LOAD;
            end
            CMD_FIRMWARE_INSTRUCTION_COMMAND: begin
              next_operating = 1'b1;
              next_fw_valid  = 1'b1;
              next_fw_is_cmd = 1'b1;
              next_fw_word   = rx_pkt[23:0];
            end
            default: next_dc_state = DC_IDLE;
          endcase
        end else if (pkt_done && operating) begin
          next_fw_valid  = 1'b1;
          next_fw_is_cmd = 1'b0;
          next_fw_word   = rx_pkt[23:0];
        end
      end
      DC_LOAD: begin
        next_load_valid = 1'b1;
        next_load_byte  = load_lo;
        next_dc_state   = DC_IDLE;
        if (!dsp_based) begin
          next_resp_valid  = 1'b1;
          next_resp_packet = {1'b1, CMD_LOAD, echo_bits, mcu_echo};
        end
      end
      default: next_dc_state = DC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dc_state    <= DC_IDLE;
      echo_bits   <= '0;
      load_lo     <= '0;
      mcu_reset   <= 1'b0;
      operating   <= 1'b0;
      load_valid  <= 1'b0;
      load_byte   <= '0;
      fw_valid    <= 1'b0;
      fw_is_cmd   <= 1'b0;
      fw_word     <= '0;
      resp_valid  <= 1'b0;
      resp_packet <= '0;
    end else begin
      dc_state    <= next_dc_state;
      echo_bits   <= next_echo_bits;
      load_lo     <= next_load_lo;
      mcu_reset   <= next_mcu_reset;
      operating   <= next_operating;
      load_valid  <= next_load_valid;
      load_byte   <= next_load_byte;
      fw_valid    <= next_fw_valid;
      fw_is_cmd   <= next_fw_is_cmd;
      fw_word     <= next_fw_word;
      resp_valid  <= next_resp_valid;
      resp_packet <= next_resp_packet;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_stop_cmd;
    pkt_done && rx_pkt[KIND_BIT] && rx_pkt[CODE_HI:CODE_LO] == CMD_STOP;
  endsequence
  sequence s_load_cmd;
    pkt_done && rx_pkt[KIND_BIT] && rx_pkt[CODE_HI:CODE_LO] == CMD_LOAD;
  endsequence

  a_stop_silences: assert property (s_stop_cmd |=>
    !resp_valid && !operating && !mcu_reset)
    else $error("stop left a reply, operation or reset active");
  a_reset_reply: assert property (
    pkt_done && rx_pkt[KIND_BIT] && code == CMD_RESET |=> resp_valid &&
    resp_packet == {1'b1, CMD_RESET, $past(rx_pkt[ECHO_HI:ECHO_LO]),
    MODULE_ID})
    else $error("reset reply malformed");
  a_load_order: assert property (s_load_cmd |=>
    load_valid && load_byte == $past(rx_pkt[15:8]) ##1
    load_valid && load_byte == $past(rx_pkt[7:0], 2))
    else $error("load bytes out of order");
  a_dsp_no_echo: assert property (
    s_load_cmd ##1 dsp_based && !resp_valid |=> !resp_valid)
    else $error("processor module echoed a load");
  a_kind_is_cmd: assert property (
    fw_valid |-> fw_is_cmd == $past(rx_pkt[KIND_BIT]))
    else $error("kind bit misread");
  a_no_data_unsynced: assert property (!synced |-> !pkt_done)
    else $error("packet completed before sync");
  a_up_layout: assert property (up_valid |=>
    host_out_valid && host_out_word[ROUTE_HI:ROUTE_LO] ==
    {$past(up_packet[KIND_BIT]), 3'h0, $past(up_slot)} &&
    host_out_word[31:16] == $past(up_packet[15:0]))
    else $error("returned word malformed");
  a_svc_kept: assert property (
    buf_valid && buf_ready && cls == CLS_SVC |=> svc_valid &&
    tx_state == TX_IDLE)
    else $error("service word sent to a module");
  a_slot_steer: assert property (
    buf_valid && buf_ready && cls != CLS_SVC |=>
    link_slot == $past(buf_word[ROUTE_LO +: SLOT_W]) &&
    tx_state == TX_SHIFT)
    else $error("slot not steered");
endmodule

// File: test/crm_fw_model.sv
// Module-side firmware and processor stand-in
`timescale 1ns/1ns
module crm_fw_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        fw_valid,
  input  wire logic        fw_is_cmd,
  input  wire logic [23:0] fw_word,
  input  wire logic        resp_valid,
  output logic             resp_ready,
  output logic [15:0]      mcu_echo,
  output logic             fw_reply_valid,
  output logic [23:0]      fw_reply
);
  logic [1:0] cnt;
  logic [7:0] n_echo;
  // ========
  // Instruction replies; replies taken one cycle in four
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt <= 2'h0;
      n_echo <= 8'h00;
      fw_reply_valid <= 1'b0;
      fw_reply <= 24'h000000;
    end else begin
      cnt <= cnt + 2'h1;
      fw_reply_valid <= fw_valid && fw_is_cmd;
      fw_reply <= ~fw_word;
      if (resp_valid && resp_ready) begin
        n_echo <= n_echo + 8'h01;
      end
    end
  end
  assign resp_ready = (cnt == 2'h0);
  assign mcu_echo = {8'hA5, n_echo};
endmodule

// File: test/crm_link_test.sv
// Self-checking bench of the crate/module command link
`timescale 1ns/1ns
module crm_link_test;
  import crm_pkg::*;
  localparam logic [15:0] MID = 16'h3C96; // Arbitrary value
  logic        mclk, reset, host_valid, host_ready, svc_valid;
  logic        link_tx, dsp_based, mcu_reset, operating;
  logic        load_valid, fw_valid, fw_is_cmd, fw_reply_valid;
  logic        resp_valid, resp_ready, up_valid, host_out_valid;
  logic [7:0]  load_byte;
  logic [3:0]  link_slot, up_slot;
  logic [15:0] mcu_echo;
  logic [23:0] fw_word, fw_reply;
  logic [24:0] resp_packet, up_packet;
  logic [31:0] host_word, svc_word, host_out_word, w;
  logic [31:0] q_rsp[$], q_fw[$], q_ld[$], q_svc[$], q_up[$];
  logic [5:0]  e;
  integer      seed, err_count, comparisons, n_acc;

  crm_link #(.BIT_DIV(4), .MODULE_ID(MID)) i_dut (.mclk, .reset,
    .host_valid, .host_word, .host_ready, .svc_valid, .svc_word, .link_tx,
    .link_slot, .link_rx(link_tx), .dsp_based, .mcu_reset, .operating,
    .load_valid, .load_byte, .mcu_echo, .fw_valid, .fw_is_cmd, .fw_word,
    .fw_reply_valid, .fw_reply, .resp_valid, .resp_packet, .resp_ready,
    .up_valid, .up_packet, .up_slot, .host_out_valid, .host_out_word);
  crm_fw_model i_fw (.mclk, .reset, .fw_valid, .fw_is_cmd, .fw_word,
    .resp_valid, .resp_ready, .mcu_echo, .fw_reply_valid, .fw_reply);

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  // ========
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop();
    $display("%0d compares, %0d bad", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic got(ref logic [31:0] q[$], input logic [31:0] v);
    if (q.size() == 0) begin
      err_count++;
      $display("BAD %0t: stray %h", $time, v);
    end else begin
      check(v, q.pop_front());
    end
  endtask
  function automatic int pend();
    pend = q_rsp.size() + q_fw.size() + q_ld.size() + q_svc.size();
    pend = pend + q_up.size();
  endfunction
  // ========
  // Host word driving
  function automatic logic [31:0] mk(input logic k, input logic [7:0] ch);
    mk = {16'($random(seed)), k, 3'h0, 4'($random(seed)), ch};
  endfunction
  task automatic put(input logic [31:0] wd);
    host_word = wd;
    host_valid = 1'b1;
    for (int k = 0; k < 999 && !host_ready; k++) @(negedge mclk);
    if (!host_ready) begin
      err_count++;
      report_and_stop();
    end
    @(negedge mclk);
  endtask
  task automatic run(input logic [31:0] wd);
    put(wd);
    host_valid = 1'b0;
    repeat (140) @(negedge mclk);
    for (int k = 0; k < 999 && pend() > 0; k++) @(negedge mclk);
    check(32'(pend()), 32'h0);
    if (pend() > 0) report_and_stop();
    $display("step done at %0t", $time);
  endtask
  // ========
  // Output watcher
  always @(posedge mclk) begin
    if (!reset) begin
      if (resp_valid && resp_ready) begin
        got(q_rsp, {7'h0, resp_packet});
        n_acc++;
      end
      if (fw_valid) got(q_fw, {7'h0, fw_is_cmd, fw_word});
      if (load_valid) got(q_ld, {24'h0, load_byte});
      if (svc_valid) got(q_svc, svc_word);
      if (host_out_valid) got(q_up, host_out_word);
    end
  end
  // ========
  // Scenarios
  initial begin
    seed = 32'h108cb48d;
    err_count = 0;
    comparisons = 0;
    n_acc = 0;
    reset = 1'b1;
    host_valid = 1'b0;
    host_word = 32'h0;
    dsp_based = 1'b0;
    up_valid = 1'b0;
    up_packet = 25'h0;
    up_slot = 4'h0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    check(32'(host_ready), 32'h0);
    run(mk(1'b0, 8'h12));
    run(mk(1'b1, 8'h00));
    check(32'(mcu_reset), 32'h0);
    e = 6'($random(seed));
    w = mk(1'b1, {2'b10, e});
    q_rsp.push_back({7'h0, 1'b1, 2'b10, e, MID});
    run(w);
    check(32'(mcu_reset), 32'h1);
    check(32'(link_slot), 32'(w[11:8]));
    run(mk(1'b1, 8'h00));
    check(32'(mcu_reset), 32'h0);
    for (int d = 0; d < 2; d++) begin
      dsp_based = 1'(d);
      e = 6'($random(seed));
      w = mk(1'b1, {2'b01, e});
      q_ld.push_back(32'(w[31:24]));
      q_ld.push_back(32'(w[23:16]));
      if (d == 0) begin
        q_rsp.push_back({7'h0, 3'b101, e, 8'hA5, 8'(n_acc)});
      end
      run(w);
    end
    run(mk(1'b1, 8'h00));
    w = mk(1'b1, {2'b11, 6'($random(seed))});
    q_fw.push_back({7'h0, 1'b1, w[7:0], w[31:16]});
    q_rsp.push_back({7'h0, 1'b1, ~{w[7:0], w[31:16]}});
    run(w);
    check(32'(operating), 32'h1);
    for (int j = 0; j < 3; j++) begin
      w = mk(1'b0, 8'($random(seed)));
      q_fw.push_back({7'h0, 1'b0, w[7:0], w[31:16]});
      put(w);
    end
    check(32'(host_ready), 32'h0);
    w = {16'($random(seed)), 2'b11, 14'($random(seed))};
    q_svc.push_back(w);
    run(w);
    for (int j = 0; j < 4; j++) begin
      up_packet = 25'($random(seed));
      up_slot = 4'($random(seed));
      up_valid = 1'b1;
      q_up.push_back({up_packet[15:0], up_packet[24], 3'h0, up_slot,
                      up_packet[23:16]});
      @(negedge mclk);
    end
    up_valid = 1'b0;
    run(mk(1'b1, 8'h00));
    check(32'(operating), 32'h0);
    report_and_stop();
  end
endmodule
